// file: design/tpcs_params.svh
// Register offsets, field positions, reset values and timing counts for the timer prescaler block
`ifndef TPCS_PARAMS_SVH
`define TPCS_PARAMS_SVH

// Register byte offsets
`define TPCS_GTSC_OFFSET      8'h00
`define TPCS_CLKSEL_OFFSET    8'h04
`define TPCS_POWER_OFFSET     8'h08
`define TPCS_STATUS_OFFSET    8'h0c
`define TPCS_PRESC_OFFSET     8'h10

// General timer sync control fields
`define TPCS_SYNC_RESET_BIT   0
`define TPCS_ASYNC_RESET_BIT  1
`define TPCS_HOLD_MODE_BIT    7

// Clock select fields: timer0 in bits 2:0, timer1 in bits 6:4
`define TPCS_SEL0_LSB         0
`define TPCS_SEL1_LSB         4
`define TPCS_SEL_RESET        3'h0

// Prescaler divider width and tap ratios
`define TPCS_DIV_W            10
`define TPCS_DIV_8            10'h007
`define TPCS_DIV_64           10'h03f
`define TPCS_DIV_256          10'h0ff
`define TPCS_DIV_1024         10'h3ff

// Power-off bit of the 16-bit timer, reset value
`define TPCS_POWER_RESET      1'b0

// Clock select codes
`define TPCS_CS_STOP          3'h0
`define TPCS_CS_DIRECT        3'h1
`define TPCS_CS_DIV8          3'h2
`define TPCS_CS_DIV64         3'h3
`define TPCS_CS_DIV256        3'h4
`define TPCS_CS_DIV1024       3'h5
`define TPCS_CS_FALL          3'h6
`define TPCS_CS_RISE          3'h7

// AHB transfer type and size codes
`define TPCS_HTRANS_NONSEQ    2'h2
`define TPCS_HSIZE_WORD       3'h2

`endif

// file: design/tpcs_pkg.sv
// Types shared by the timer prescaler and clock select block
package tpcs_pkg;

   // Clock select code of one timer
   typedef logic [2:0] tpcs_sel_t;

   // Bus slave states
   typedef enum logic [1:0] {
      TPCS_IDLE  = 2'b01,
      TPCS_WDATA = 2'b10
   } tpcs_bus_e;

   // One pending AHB address phase
   typedef struct packed {
      logic       write;
      logic [7:0] addr;
   } tpcs_addr_s;

   // Prescaler taps presented to each timer
   typedef struct packed {
      logic tap8;
      logic tap64;
      logic tap256;
      logic tap1024;
   } tpcs_taps_s;

endpackage

// file: design/tpcs_pin_sync.sv
// External count pin sampler and edge detector
`timescale 1ns/1ps
`default_nettype none
module tpcs_pin_sync
   import tpcs_pkg::*;
(
   // Clock and reset
   input  wire logic hclk,
   input  wire logic hresetn,
   // Pin and selection
   input  wire logic pin,
   input  wire logic rise_sel,
   // Detected edges
   output logic      rise,
   output logic      fall
);

   logic latch_q;
   logic sync_q;
   logic edge_q;

   // Transparent while the clock is high: half-cycle sample stage
   always_latch begin
      if (hclk) begin
         latch_q = pin;
      end
   end

   // Two rising-edge registers behind the latch
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync_q <= 1'b0;
         edge_q <= 1'b0;
      end else begin
         sync_q <= latch_q;
         edge_q <= sync_q;
      end
   end

   // One pulse per edge; total pin-to-count delay 2.5 to 3.5 cycles
   assign rise = sync_q & ~edge_q & rise_sel;
   assign fall = ~sync_q & edge_q & ~rise_sel;

endmodule
`default_nettype wire

// file: design/tpcs_clock_select.sv
// Timer prescaler, per-timer clock select and sync control with AHB-Lite registers
//
// The AHB-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "tpcs_params.svh"
module tpcs_clock_select
   import tpcs_pkg::*;
(
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // External count pins
   input  wire logic        ext_count_in_0,
   input  wire logic        ext_count_in_1,
   // Timer tick enables and held resets
   output logic             timer0_tick,
   output logic             timer1_tick,
   output logic             sync_prescaler_reset,
   output logic             async_prescaler_reset
);

   // Software state
   logic                    sync_hold_mode;
   tpcs_sel_t               sel0;
   tpcs_sel_t               sel1;
   logic                    timer16_power_off;
   logic [`TPCS_DIV_W-1:0]  prescale_count;
   tpcs_addr_s              pend;
   tpcs_bus_e               bus_state;
   logic [31:0]             next_rdata;
   logic                    wr_gtsc;
   logic                    wr_sel;
   logic                    wr_power;
   tpcs_taps_s              taps;
   logic                    rise0;
   logic                    fall0;
   logic                    rise1;
   logic                    fall1;
   logic                    next_tick0;
   logic                    next_tick1;

   // Tap pulse when the low divider bits are all ones
   function automatic logic tap_hit(input logic [`TPCS_DIV_W-1:0] cnt,
                                    input logic [`TPCS_DIV_W-1:0] mask);
      tap_hit = ((cnt & mask) == mask);
   endfunction

   // Select decode shared by both timers
   function automatic logic tick_of(input tpcs_sel_t sel, input tpcs_taps_s t,
                                    input logic r, input logic f);
      case (sel)
         `TPCS_CS_STOP:    tick_of = 1'b0;
         `TPCS_CS_DIRECT:  tick_of = 1'b1;
         `TPCS_CS_DIV8:    tick_of = t.tap8;
         `TPCS_CS_DIV64:   tick_of = t.tap64;
         `TPCS_CS_DIV256:  tick_of = t.tap256;
         `TPCS_CS_DIV1024: tick_of = t.tap1024;
         `TPCS_CS_FALL:    tick_of = f;
         `TPCS_CS_RISE:    tick_of = r;
         default:          tick_of = 1'b0;
      endcase
   endfunction

   // Address phase taken; writes land in the following data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bus_state <= TPCS_IDLE;
         pend      <= '0;
      end else if (hready) begin
         if (hsel && htrans == `TPCS_HTRANS_NONSEQ) begin
            bus_state  <= TPCS_WDATA;
            pend.write <= hwrite;
            pend.addr  <= haddr;
         end else begin
            bus_state <= TPCS_IDLE;
         end
      end
   end

   // Zero-wait slave, always OKAY
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   // Data phase write strobes
   assign wr_gtsc  = (bus_state == TPCS_WDATA) && pend.write
                     && pend.addr == `TPCS_GTSC_OFFSET;
   assign wr_sel   = (bus_state == TPCS_WDATA) && pend.write
                     && pend.addr == `TPCS_CLKSEL_OFFSET;
   assign wr_power = (bus_state == TPCS_WDATA) && pend.write
                     && pend.addr == `TPCS_POWER_OFFSET;

   // Sync control: reset bits kept only under hold mode
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync_hold_mode        <= 1'b0;
         sync_prescaler_reset  <= 1'b0;
         async_prescaler_reset <= 1'b0;
      end else if (wr_gtsc) begin
         sync_hold_mode        <= hwdata[`TPCS_HOLD_MODE_BIT];
         // Held only while hold mode is written one
         sync_prescaler_reset  <= hwdata[`TPCS_SYNC_RESET_BIT]
                                  & hwdata[`TPCS_HOLD_MODE_BIT];
         async_prescaler_reset <= hwdata[`TPCS_ASYNC_RESET_BIT]
                                  & hwdata[`TPCS_HOLD_MODE_BIT];
      end else if (!sync_hold_mode) begin
         // Cleared whenever hold mode is off; a plain reset request never sets these bits
         sync_prescaler_reset  <= 1'b0;
         async_prescaler_reset <= 1'b0;
      end
   end

   // Clock selects and power-off bit
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sel0              <= `TPCS_SEL_RESET;
         sel1              <= `TPCS_SEL_RESET;
         timer16_power_off <= `TPCS_POWER_RESET;
      end else begin
         if (wr_sel) begin
            // Independent selections per timer
            sel0 <= hwdata[`TPCS_SEL0_LSB +: 3];
            sel1 <= hwdata[`TPCS_SEL1_LSB +: 3];
         end
         if (wr_power) begin
            timer16_power_off <= hwdata[0];
         end
      end
   end

   // Free-running shared divider; only a sync prescaler reset restarts it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         prescale_count <= '0;
      end else if (sync_prescaler_reset || (wr_gtsc && hwdata[`TPCS_SYNC_RESET_BIT])) begin
         prescale_count <= '0;
      end else begin
         prescale_count <= prescale_count + 10'h001;
      end
   end

   // Taps; any phase of the divider gives 1 to N cycles to first tick
   assign taps.tap8    = tap_hit(prescale_count, `TPCS_DIV_8);
   assign taps.tap64   = tap_hit(prescale_count, `TPCS_DIV_64);
   assign taps.tap256  = tap_hit(prescale_count, `TPCS_DIV_256);
   assign taps.tap1024 = tap_hit(prescale_count, `TPCS_DIV_1024);

   // Pin samplers; read regardless of pin direction
   tpcs_pin_sync u_pin0 (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .pin      (ext_count_in_0),
      .rise_sel (sel0[0]),
      .rise     (rise0),
      .fall     (fall0)
   );

   tpcs_pin_sync u_pin1 (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .pin      (ext_count_in_1),
      .rise_sel (sel1[0]),
      .rise     (rise1),
      .fall     (fall1)
   );

   // Halted while the sync prescaler reset is held; 16-bit timer gated by power
   always_comb begin
      next_tick0 = tick_of(sel0, taps, rise0, fall0) & ~sync_prescaler_reset;
      next_tick1 = tick_of(sel1, taps, rise1, fall1) & ~sync_prescaler_reset
                   & ~timer16_power_off;
   end

   // Registered single-cycle tick enables
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         timer0_tick <= 1'b0;
         timer1_tick <= 1'b0;
      end else begin
         timer0_tick <= next_tick0;
         timer1_tick <= next_tick1;
      end
   end

   // Read mux; unmapped offsets read zero
   always_comb begin
      next_rdata = 32'h0000_0000;
      case (haddr)
         `TPCS_GTSC_OFFSET: begin
            next_rdata[`TPCS_HOLD_MODE_BIT]   = sync_hold_mode;
            next_rdata[`TPCS_SYNC_RESET_BIT]  = sync_prescaler_reset;
            next_rdata[`TPCS_ASYNC_RESET_BIT] = async_prescaler_reset;
         end
         `TPCS_CLKSEL_OFFSET: begin
            next_rdata[`TPCS_SEL0_LSB +: 3] = sel0;
            next_rdata[`TPCS_SEL1_LSB +: 3] = sel1;
         end
         `TPCS_POWER_OFFSET:  next_rdata[0] = timer16_power_off;
         `TPCS_STATUS_OFFSET: next_rdata[1:0] = {timer1_tick, timer0_tick};
         `TPCS_PRESC_OFFSET:  next_rdata[`TPCS_DIV_W-1:0] = prescale_count;
         default:             next_rdata = 32'h0000_0000;
      endcase
   end

   // Read data captured at the address phase, standing through the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (hready && hsel && htrans == `TPCS_HTRANS_NONSEQ && !hwrite) begin
         hrdata <= next_rdata;
      end
   end

endmodule
`default_nettype wire

// file: tb/tpcs_monitor.sv
// Checker on the prescaler block ports
`timescale 1ns/1ps
`default_nettype none
module tpcs_monitor
   import tpcs_pkg::*;
(
   // Clock, reset and bus
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [7:0]  haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic [31:0] hwdata,
   // Pin, ticks and resets
   input wire logic        ext_count_in_0,
   input wire logic        timer0_tick,
   input wire logic        timer1_tick,
   input wire logic        sync_prescaler_reset,
   input wire logic        async_prescaler_reset
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic       ap_v;
   logic       pwr;
   logic       gt_wr;
   logic [7:0] ap_a;
   logic [7:0] gt;
   tpcs_sel_t  s0;
   assign gt_wr = ap_v && ap_a == 8'h00;
   // Shadow of written registers, updated on the same edge as the design
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_v <= 1'b0;
         ap_a <= 8'h00;
         gt   <= 8'h00;
         s0   <= 3'h0;
         pwr  <= 1'b0;
      end else begin
         ap_v <= hsel && hready && htrans == 2'h2 && hwrite;
         ap_a <= haddr;
         if (gt_wr)
            gt <= hwdata[7:0];
         if (ap_v && ap_a == 8'h04)
            s0 <= hwdata[2:0];
         if (ap_v && ap_a == 8'h08)
            pwr <= hwdata[0];
      end
   end
   // Tick output lags its select by one registered cycle, hence the past values
   AST_DIRECT: assert property ($past(s0) == 3'h1 && !$past(gt[7]) |-> timer0_tick)
      else $error("direct tick missing");
   AST_TAP8: assert property (timer0_tick && $past(s0) == 3'h2 |=>
      (!timer0_tick || $past(s0) != 3'h2)[*7]) else $error("tap8 ticks too close");
   AST_HOLD: assert property (gt[7] |-> sync_prescaler_reset == gt[0]
      && async_prescaler_reset == gt[1]) else $error("held reset lost");
   AST_PULSE: assert property (gt_wr && hwdata[0] && !hwdata[7]
      |=> !sync_prescaler_reset) else $error("reset bit not cleared");
   // Release clears both bits whatever was written beside the cleared hold bit
   AST_REL: assert property ($fell(gt[7]) |->
      !sync_prescaler_reset && !async_prescaler_reset) else $error("release failed");
   AST_MASK: assert property (sync_prescaler_reset && $past(sync_prescaler_reset)
      |-> !timer0_tick && !timer1_tick) else $error("tick under held reset");
   AST_PWR: assert property (pwr && $past(pwr) |-> !timer1_tick)
      else $error("timer1 ticks while off");
   AST_PIN: assert property ($rose(ext_count_in_0) && s0 == 3'h7 && !gt[7]
      |-> ##[2:5] timer0_tick) else $error("pin tick late");
   cover property (timer0_tick && s0 == 3'h5);
   cover property (gt[7] && sync_prescaler_reset);
   cover property ($fell(gt[7]));
endmodule
bind tpcs_clock_select tpcs_monitor u_mon (.hclk, .hresetn, .hsel, .haddr, .htrans,
   .hwrite, .hready, .hwdata, .ext_count_in_0, .timer0_tick, .timer1_tick,
   .sync_prescaler_reset, .async_prescaler_reset);
`default_nettype wire

// file: tb/tpcs_pulse_src.sv
// External pulse source on both count pins
`timescale 1ns/1ps
`default_nettype none
module tpcs_pulse_src #(
   parameter int HALF = 3
) (
   // Clock and run control
   input  wire logic hclk,
   input  wire logic go,
   // Count pins, second one inverted
   output logic      pin0,
   output logic      pin1
);
   int   cnt = 0;
   logic lvl = 1'b0;
   // One driver per pin: both follow the same level register
   assign pin0 = lvl;
   assign pin1 = ~lvl;
   // Each phase lasts HALF cycles, under clk/2.5
   // Level holds while stopped, so selects change on a stable pin
   always @(posedge hclk) begin
      if (!go)
         cnt <= 0;
      else if (cnt == HALF - 1) begin
         cnt  <= 0;
         lvl <= ~lvl;
      end else
         cnt <= cnt + 1;
   end
endmodule
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the timer prescaler and clock select block
`timescale 1ns/1ps
`default_nettype none
`include "tpcs_params.svh"
module testbench;
   logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, go = 1'b0;
   logic [7:0]  haddr = 8'h00;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] hwdata = 32'h0, hrdata, q, q2;
   logic        hreadyout, hresp, p0, p1, t0, t1, srst, arst;
   int          err_count = 0, cmp_count = 0, c0 = 0, c1 = 0, b0, b1, d0, d1;
   logic [7:0]  ra[5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h14};
   int          ratio[4] = '{8, 64, 256, 1024};
   logic [31:0] pin_sel[3] = '{32'h67, 32'h76, 32'h0};
   int          pin_exp[3] = '{5, 5, 0};
   tpcs_clock_select dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
      .hsize(`TPCS_HSIZE_WORD), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
      .ext_count_in_0(p0), .ext_count_in_1(p1), .timer0_tick(t0), .timer1_tick(t1),
      .sync_prescaler_reset(srst), .async_prescaler_reset(arst));
   tpcs_pulse_src src (.hclk, .go, .pin0(p0), .pin1(p1));
   initial forever #12.5 hclk = ~hclk;
   // Running tick counts; scenarios take differences
   always @(posedge hclk) begin
      c0 <= c0 + t0;
      c1 <= c1 + t1;
   end
   // One AHB-Lite single transfer, waiting on hready in both phases
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= a;
      hwrite <= w;
      htrans <= `TPCS_HTRANS_NONSEQ;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         err_count++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   // Skip two edges so the old select has left the output register
   task automatic span(input int n);
      repeat (2) @(posedge hclk);
      b0 = c0;
      b1 = c1;
      repeat (n) @(posedge hclk);
      d0 = c0 - b0;
      d1 = c1 - b1;
   endtask
   task automatic tally_and_finish;
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Run is about 5700 cycles; cut a hang well beyond that
   initial begin
      repeat (40000) @(posedge hclk);
      err_count++;
      tally_and_finish();
   end
   initial begin
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      // Reset values, and an unmapped place that ignores writes
      xfer(1'b1, 8'h14, 32'hffffffff, q);
      foreach (ra[i]) begin
         xfer(1'b0, ra[i], 32'h0, q);
         chk("reset value", 32'h0, q);
      end
      // Direct clock on both, then timer1 powered off
      xfer(1'b1, 8'h04, 32'h11, q);
      span(20);
      chk("t0 direct", 20, d0);
      chk("t1 direct", 20, d1);
      xfer(1'b1, 8'h08, 32'h1, q);
      span(20);
      chk("t0 power", 20, d0);
      chk("t1 power", 0, d1);
      xfer(1'b1, 8'h08, 32'h0, q);
      // Divider keeps counting across a select change
      xfer(1'b0, 8'h10, 32'h0, q);
      xfer(1'b1, 8'h04, 32'h0, q2);
      xfer(1'b0, 8'h10, 32'h0, q2);
      chk("divider step", 32'h6, (q2 - q) & 32'h3ff);
      // Each tap on timer0 after a prescaler reset, timer1 kept on /8
      for (int i = 0; i < 4; i++) begin
         xfer(1'b1, 8'h04, 32'h20 | (i + 2), q);
         xfer(1'b1, 8'h00, 32'h1, q);
         // Divider zeroed on the write edge, one step on by the read's address edge
         xfer(1'b0, 8'h10, 32'h0, q);
         chk("divider restart", 32'h1, q);
         xfer(1'b0, 8'h00, 32'h0, q);
         chk("reset bit", 32'h0, q);
         span(4 * ratio[i]);
         chk("t0 tap", 4, d0);
         chk("t1 tap8", ratio[i] / 2, d1);
      end
      // Hold mode keeps both resets and halts ticks and divider
      xfer(1'b1, 8'h04, 32'h11, q);
      xfer(1'b1, 8'h00, 32'h83, q);
      span(20);
      chk("t0 held", 0, d0 + d1);
      chk("resets held", 32'h3, {30'h0, arst, srst});
      xfer(1'b0, 8'h10, 32'h0, q);
      chk("divider held", 32'h0, q);
      xfer(1'b0, 8'h00, 32'h0, q);
      chk("hold kept", 32'h83, q);
      xfer(1'b1, 8'h00, 32'h0, q);
      span(10);
      chk("both resumed", 20, d0 + d1);
      chk("resets released", 32'h0, {30'h0, arst, srst});
      xfer(1'b0, 8'h00, 32'h0, q);
      chk("hold cleared", 32'h0, q);
      // Pin edges of both senses bypass the divider; select 0 gives none
      for (int i = 0; i < 3; i++) begin
         xfer(1'b1, 8'h04, pin_sel[i], q);
         repeat (2) @(posedge hclk);
         b0 = c0;
         b1 = c1;
         go <= 1'b1;
         repeat (30) @(posedge hclk);
         go <= 1'b0;
         repeat (8) @(posedge hclk);
         chk("t0 pin", pin_exp[i], c0 - b0);
         chk("t1 pin", pin_exp[i], c1 - b1);
      end
      tally_and_finish();
   end
endmodule
`default_nettype wire
